// ---- design/vsp_pkg.sv ----
// Purpose: shared constants and types of the video sync processor
// Assumes: 25 MHz system clock, APB register access
// Notes: register indices map to byte address four times the index
package vsp_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_THRESH = 8'h11;
  localparam logic [7:0] IDX_HPOL = 8'h12;
  localparam logic [7:0] IDX_CPOL = 8'h18;
  localparam logic [7:0] IDX_SLICE = 8'h1d;
  localparam logic [7:0] IDX_CTRL = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;
  // field positions
  localparam int HPOL_LSB = 4;
  localparam int CPOL_LSB = 5;
  localparam int SLICE_LSB = 3;
  localparam int CTRL_SRC_BIT = 5;
  localparam int CTRL_EXTCLK_BIT = 6;
  localparam int CTRL_INSEL_BIT = 7;
  localparam int STAT_FIELD_BIT = 16;
  // reset values
  localparam logic [7:0] RST_THRESH = 8'h20;
  localparam logic [7:0] RST_HPOL = 8'h30;
  localparam logic [7:0] RST_CPOL = 8'h60;
  localparam logic [7:0] RST_SLICE = 8'h80;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // timing
  localparam int CLK_NS = 40;
  localparam int UNIT_NS = 200;
  localparam logic [2:0] UNIT_CYC = 3'((UNIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] HS_PULSE_CYC = 2'h3;

  typedef struct packed {
    logic [7:0] thresh;
    logic [7:0] hpol;
    logic [7:0] cpol;
    logic [7:0] slice;
    logic [7:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] hs_m;
    logic [1:0] hs_s;
    logic [1:0] gs_m;
    logic [1:0] gs_s;
    logic co_m;
    logic co_s;
    logic comp;
    logic [2:0] unit;
    logic [7:0] wid;
    logic [7:0] tail;
    logic vs;
    logic [1:0] hs_pulse;
    logic hs_out;
    logic [15:0] line_cnt;
    logic [15:0] line_len;
    logic [11:0] hcount;
    logic [11:0] hcount_lat;
    logic field;
    logic fs_out;
    logic coast;
    logic pll_ref;
    logic gs_out;
  } vsp_state_type;
endpackage

// ---- design/vsp_sync_proc.sv ----
// Purpose: sync processor of a video capture front end
// Assumes: sync inputs and coast pin are asynchronous to clk_i
// Notes: the analog slicer and clock phase shifter sit outside this logic
// Operation
// RQ1: sampling clock phase is set in 32 steps of 11.25 degrees.
// RQ2: line sync output gets the same phase shift as the sampling clock.
// RQ3: phase stepping keeps working with an external pixel clock.
// RQ4: while coast is active the PLL reference is held, line sync ignored.
// RQ5: coast polarity comes from bits 6:5 of register coast_polarity_config; the code reads bit 5 only.
// RQ6: line sync polarity comes from bits 5:4 of register hsync_polarity_config.
// RQ7: polarity value one means active high, zero active low.
// RQ8: internal coast is derived from the vertical sync.
// RQ9: outputs field flag, line and frame sync, line count, green sync.
// RQ10: separator input is the slicer output or the line sync inputs.
// RQ11: slicer level is bits 7:3 of register slicer_level_config; output is composite.
// RQ12: separator threshold is N from register separator_threshold times 200 ns.
// RQ13: pulses shorter than the threshold are dropped, longer pass as vsync.
// RQ14: extracted vertical sync lags the original by the threshold.
// RQ15: the 200 ns unit may vary twenty percent; logic must tolerate it.
// RQ16: vsync filter keeps edges apart from line sync, makes field flag.
// RQ17: line sync regenerator rebuilds clean line sync for counting.
`timescale 1ns/1ns
`default_nettype none
module vsp_sync_proc (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [1:0] line_sync_inputs_i,
  input wire logic [1:0] green_sync_inputs_i,
  input wire logic coast_pin_i,
  output logic [4:0] phase_step_o,
  output logic ext_clk_sel_o,
  output logic [4:0] slicer_level_o,
  output logic coast_o,
  output logic pll_ref_o,
  output logic line_sync_output_o,
  output logic frame_sync_output_o,
  output logic green_sync_output_o,
  output logic field_o
);
  // ==========================================================
  // state
  vsp_pkg::vsp_state_type s;
  vsp_pkg::vsp_state_type next_s;
  logic [7:0] idx;
  logic setup;
  logic wr;
  logic hs_act;
  logic gs_act;
  logic co_act;
  logic comp;
  logic unit_tick;
  logic hs_edge;
  logic vs_rise;

  // map a byte address to a register index; misaligned is unmapped
  function automatic logic mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    mapped = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
      (i == vsp_pkg::IDX_THRESH || i == vsp_pkg::IDX_HPOL ||
       i == vsp_pkg::IDX_CPOL || i == vsp_pkg::IDX_SLICE ||
       i == vsp_pkg::IDX_CTRL || i == vsp_pkg::IDX_STATUS);
  endfunction

  // apply a programmed polarity: one is active high
  function automatic logic active(input logic lvl, input logic pol);
    active = pol ? lvl : ~lvl; // see RQ7
  endfunction

  // ==========================================================
  // decoded terms
  assign idx = paddr_i[9:2];
  assign setup = psel_i && !penable_i && !s.pready;
  assign wr = psel_i && penable_i && s.pready && pwrite_i && !s.pslverr;
  // line sync input selected by ctrl, polarity per input
  assign hs_act = active(s.hs_s[s.ctrl[vsp_pkg::CTRL_INSEL_BIT]],
    s.hpol[vsp_pkg::HPOL_LSB + 32'(s.ctrl[vsp_pkg::CTRL_INSEL_BIT])]); // see RQ6
  // green sync is always negative going
  assign gs_act = ~s.gs_s[s.ctrl[vsp_pkg::CTRL_INSEL_BIT]];
  assign co_act = active(s.co_s, s.cpol[vsp_pkg::CPOL_LSB]); // see RQ5
  // composite source: line sync inputs or slicer output
  assign comp = s.ctrl[vsp_pkg::CTRL_SRC_BIT] ? hs_act : gs_act; // see RQ10
  assign unit_tick = (s.unit == vsp_pkg::UNIT_CYC - 3'h1);
  // regenerator accepts an edge only past half the last line period
  assign hs_edge = comp && !s.comp &&
    (s.line_cnt >= {1'b0, s.line_len[15:1]}); // see RQ17
  // same condition that sets vs below; kept off next_s to avoid a loop
  assign vs_rise = comp && s.thresh != 8'h0 && s.wid >= s.thresh &&
    !s.vs;

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    // synchronisers; first stage feeds only the second
    next_s.hs_m = line_sync_inputs_i;
    next_s.hs_s = s.hs_m;
    next_s.gs_m = green_sync_inputs_i;
    next_s.gs_s = s.gs_m;
    next_s.co_m = coast_pin_i;
    next_s.co_s = s.co_m;

    // apb: answer one cycle after setup, zero wait states after that
    next_s.pready = setup;
    next_s.pslverr = setup && !mapped(paddr_i);
    next_s.prdata = 32'h0;
    // refused reads return zero, misaligned ones included
    if (setup && !pwrite_i && mapped(paddr_i)) begin
      case (idx)
        vsp_pkg::IDX_THRESH: next_s.prdata = {24'h0, s.thresh};
        vsp_pkg::IDX_HPOL: next_s.prdata = {24'h0, s.hpol};
        vsp_pkg::IDX_CPOL: next_s.prdata = {24'h0, s.cpol};
        vsp_pkg::IDX_SLICE: next_s.prdata = {24'h0, s.slice};
        vsp_pkg::IDX_CTRL: next_s.prdata = {24'h0, s.ctrl};
        vsp_pkg::IDX_STATUS: begin
          next_s.prdata = {20'h0, s.hcount_lat};
          next_s.prdata[vsp_pkg::STAT_FIELD_BIT] = s.field;
        end
        default: next_s.prdata = 32'h0;
      endcase
    end
    if (wr) begin
      case (idx)
        vsp_pkg::IDX_THRESH: next_s.thresh = pwdata_i[7:0]; // see RQ12
        vsp_pkg::IDX_HPOL: next_s.hpol = pwdata_i[7:0];
        vsp_pkg::IDX_CPOL: next_s.cpol = pwdata_i[7:0];
        vsp_pkg::IDX_SLICE: next_s.slice = pwdata_i[7:0]; // see RQ11
        vsp_pkg::IDX_CTRL: next_s.ctrl = pwdata_i[7:0]; // see RQ1
        default: next_s.ctrl = s.ctrl;
      endcase
    end

    // separator time base restarts on every composite edge, so the
    // threshold is counted from the pulse's own start
    next_s.comp = comp;
    next_s.unit = (comp != s.comp || unit_tick) ? 3'h0 : s.unit + 3'h1;
    // width in 200 ns units while the pulse lasts; wide margin against
    // timebase drift since line and frame pulses differ hugely
    if (!comp) begin
      next_s.wid = 8'h0; // see RQ15
    end else if (unit_tick && s.wid != 8'hff) begin
      next_s.wid = s.wid + 8'h1;
    end
    // pass as vsync once width reaches N units; shorter pulses never do
    if (comp && s.thresh != 8'h0 && s.wid >= s.thresh) begin
      next_s.vs = 1'b1; // see RQ13
      next_s.tail = s.thresh;
    end else if (!comp && s.vs) begin
      // trailing edge also held back by N units
      if (s.tail == 8'h0) begin
        next_s.vs = 1'b0; // see RQ14
      end else if (unit_tick) begin
        next_s.tail = s.tail - 8'h1;
      end
    end

    // line sync regenerator and line period measurement
    if (s.line_cnt != 16'hffff) begin
      next_s.line_cnt = s.line_cnt + 16'h1;
    end
    if (s.hs_pulse != 2'h0) begin
      next_s.hs_pulse = s.hs_pulse - 2'h1;
    end
    if (hs_edge) begin
      next_s.line_len = s.line_cnt;
      next_s.line_cnt = 16'h0;
      next_s.hs_pulse = vsp_pkg::HS_PULSE_CYC;
      if (s.hcount != 12'hfff) begin
        next_s.hcount = s.hcount + 12'h1;
      end
    end
    next_s.hs_out = hs_edge || (s.hs_pulse > 2'h1); // see RQ2

    // vsync filter: field flag and line count per frame
    if (vs_rise) begin
      next_s.hcount_lat = s.hcount; // see RQ9
      next_s.hcount = 12'h0;
      next_s.field = s.line_cnt >= {1'b0, s.line_len[15:1]}; // see RQ16
    end
    // frame edge never rises with a line edge; the rise slips one cycle
    if (!(hs_edge && vs_rise)) begin
      next_s.fs_out = next_s.vs; // see RQ16
    end

    // coast from pin or from vsync; PLL reference frozen while active
    next_s.coast = co_act || s.vs; // see RQ8
    next_s.pll_ref = s.coast ? s.pll_ref : hs_act; // see RQ4
    next_s.gs_out = gs_act;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.thresh <= vsp_pkg::RST_THRESH;
      s.hpol <= vsp_pkg::RST_HPOL;
      s.cpol <= vsp_pkg::RST_CPOL;
      s.slice <= vsp_pkg::RST_SLICE;
      s.ctrl <= vsp_pkg::RST_CTRL;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs; phase code serves both sampling clock and line sync
  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign phase_step_o = s.ctrl[4:0]; // see RQ1
  assign ext_clk_sel_o = s.ctrl[vsp_pkg::CTRL_EXTCLK_BIT]; // see RQ3
  assign slicer_level_o = s.slice[7:vsp_pkg::SLICE_LSB]; // see RQ11
  assign coast_o = s.coast;
  assign pll_ref_o = s.pll_ref;
  assign line_sync_output_o = s.hs_out;
  assign frame_sync_output_o = s.fs_out;
  assign green_sync_output_o = s.gs_out;
  assign field_o = s.field;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  apb_answer_a: assert property (
    psel_i && !penable_i && !pready_o |=> pready_o)
    else $error("apb setup not answered next cycle");
  apb_ready_pulse_a: assert property (
    pready_o |=> !pready_o)
    else $error("pready stood more than one cycle");
  coast_vsync_a: assert property ( // see RQ8
    s.vs |=> coast_o)
    else $error("coast not raised during vsync");
  pll_hold_a: assert property ( // see RQ4
    coast_o |=> $stable(pll_ref_o))
    else $error("pll reference moved during coast");
  vsync_width_a: assert property ( // see RQ13
    $rose(s.vs) |-> $past(s.wid) >= s.thresh && s.thresh != 8'h0)
    else $error("vsync passed a short pulse");
  vsync_lag_a: assert property ( // see RQ14
    s.vs && !s.comp && s.tail != 8'h0 |=> s.vs)
    else $error("vsync trailing edge not delayed");
  phase_same_a: assert property ( // see RQ2
    phase_step_o == s.ctrl[4:0])
    else $error("phase code split");
  count_latch_a: assert property ( // see RQ9
    $rose(s.vs) |-> s.hcount == 12'h0)
    else $error("line count not restarted at frame");
  line_pulse_a: assert property ( // see RQ17
    $rose(line_sync_output_o) |-> line_sync_output_o [*3] ##1
      !line_sync_output_o)
    else $error("regenerated line sync wrong width");
  unmapped_err_a: assert property (
    psel_i && !penable_i && !pready_o && paddr_i[1:0] != 2'h0
      |=> pslverr_o)
    else $error("misaligned access not refused");

  // ==========================================================
  // further checks on the apb answer and the sync path
  // these watch the registered state, so a broken next-state term
  // shows one cycle after it goes wrong; drift is not modelled

  // refused reads must not leak register contents
  err_read_a: assert property (
    pslverr_o |-> prdata_o == 32'h0)
    else $error("refused read returned data");

  // an answer only ever follows a setup cycle
  ready_cause_a: assert property (
    pready_o |-> $past(psel_i && !penable_i))
    else $error("pready without a setup");

  // green sync output follows the synchronised input
  gsync_follow_a: assert property ( // see RQ9
    gs_act |=> green_sync_output_o)
    else $error("green sync output missed a pulse");

  gsync_idle_a: assert property ( // see RQ9
    !gs_act |=> !green_sync_output_o)
    else $error("green sync output stuck high");

  // pin coast at its programmed polarity raises coast
  coast_pin_a: assert property ( // see RQ5
    co_act |=> coast_o)
    else $error("coast pin ignored");

  // with neither pin nor vsync, coast must drop
  coast_clear_a: assert property ( // see RQ8
    !co_act && !s.vs |=> !coast_o)
    else $error("coast stuck without a cause");

  // outside coast the reference tracks the active line sync
  pll_track_a: assert property ( // see RQ4
    !coast_o |=> pll_ref_o == $past(hs_act))
    else $error("pll reference not tracking line sync");

  // width counter clears while the composite is idle
  wid_clear_a: assert property ( // see RQ15
    !comp |=> s.wid == 8'h0)
    else $error("pulse width not cleared");

  // a zero threshold keeps the separator quiet
  sep_off_a: assert property ( // see RQ12
    s.thresh == 8'h0 && !s.vs |=> !s.vs)
    else $error("separator fired with zero threshold");

  // once the tail has run out, vsync ends
  vsync_end_a: assert property ( // see RQ14
    s.vs && !comp && s.tail == 8'h0 |=> !s.vs)
    else $error("vsync outstayed its tail");

  // field flag only moves at a frame start
  field_hold_a: assert property ( // see RQ16
    !vs_rise |=> $stable(field_o))
    else $error("field flag moved mid frame");

  // frame output follows vsync unless its rise would meet a line edge
  frame_follow_a: assert property ( // see RQ16
    !(hs_edge && vs_rise) |=> frame_sync_output_o == s.vs)
    else $error("frame output lost track of vsync");

  frame_apart_a: assert property ( // see RQ16
    hs_edge && vs_rise |=> !frame_sync_output_o)
    else $error("frame and line edges switched together");

  // an early edge leaves the measured line period alone
  line_refuse_a: assert property ( // see RQ17
    comp && !s.comp && s.line_cnt < {1'b0, s.line_len[15:1]}
      |=> $stable(s.line_len))
    else $error("early line edge accepted");

  // every accepted edge outside a frame start bumps the per frame line count until it saturates
  line_count_a: assert property ( // see RQ17
    hs_edge && !vs_rise && s.hcount != 12'hfff
      |=> s.hcount == $past(s.hcount) + 12'h1)
    else $error("line edge not counted");

  // run length of the regenerated line pulse, check helper only;
  // a counter is cheaper for the tools than a long repetition
  logic [2:0] ls_run;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ls_run <= 3'h0;
    end else if (!line_sync_output_o) begin
      ls_run <= 3'h0;
    end else if (ls_run != 3'h7) begin
      ls_run <= ls_run + 3'h1;
    end
  end

  line_run_a: assert property ( // see RQ17
    ls_run <= {1'b0, vsp_pkg::HS_PULSE_CYC})
    else $error("line pulse ran too long");
endmodule // vsp_sync_proc
`default_nettype wire

// ---- tb/vsp_sync_proc_test.sv ----
// Purpose: self-checking bench of the video sync processor
// Assumes: 25 MHz clock, apb answer waited for, video source model
// Notes: timebase drift is not modelled, so lag windows are wide
`timescale 1ns/1ns
`default_nettype none
module vsp_sync_proc_test;
  typedef struct packed {
    logic wr;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } vsp_row_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic [4:0] phase, slice;
  logic [1:0] line_in, green_in;
  logic pready, pslverr, pll_ref, coast, fs, ls, gs, field, ext, pin, e, c, g;
  int err_count = 0;
  int checks_done = 0;
  int n, t, hs;
  // reset values first, then write and read back, one unmapped word
  vsp_row_type rows [11] = '{
    '{1'b0, 12'h044, 32'h0, 32'h20, 1'b0}, '{1'b0, 12'h048, 32'h0, 32'h30, 1'b0},
    '{1'b0, 12'h060, 32'h0, 32'h60, 1'b0}, '{1'b0, 12'h074, 32'h0, 32'h80, 1'b0},
    '{1'b0, 12'h0c0, 32'h0, 32'h00, 1'b0}, '{1'b1, 12'h074, 32'ha8, 32'h0, 1'b0},
    '{1'b0, 12'h074, 32'h0, 32'ha8, 1'b0}, '{1'b1, 12'h0c0, 32'h5f, 32'h0, 1'b0},
    '{1'b0, 12'h0c0, 32'h0, 32'h5f, 1'b0}, '{1'b0, 12'h100, 32'h0, 32'h0, 1'b1},
    '{1'b1, 12'h044, 32'h02, 32'h0, 1'b0}};
  // ==========
  // clock, design and source
  always #20 clk_i = ~clk_i;
  vsp_sync_proc u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .line_sync_inputs_i(line_in), .green_sync_inputs_i(green_in),
    .coast_pin_i(pin), .phase_step_o(phase), .ext_clk_sel_o(ext),
    .slicer_level_o(slice), .coast_o(coast), .pll_ref_o(pll_ref),
    .line_sync_output_o(ls), .frame_sync_output_o(fs),
    .green_sync_output_o(gs), .field_o(field));
  vsp_video_src src (.clk_i(clk_i), .line_o(line_in), .green_o(green_in),
    .coast_o(pin));
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 8);
    if (k >= 8) begin
      err_count++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // count line output rises and pll ref moves; t is the last rise
  task automatic run_lines(input logic a);
    logic p, pp;
    p = 1'b1;
    pp = pll_ref;
    hs = 0;
    n = 0;
    t = 0;
    fork
      src.lines(a, 4);
      for (int i = 1; i <= 165; i++) begin
        @(posedge clk_i);
        if (ls === 1'b1 && p === 1'b0) begin
          hs++;
          t = i;
        end
        if (pll_ref !== pp) n++;
        p = ls;
        pp = pll_ref;
      end
    join
  endtask
  // t is the cycle of the first frame sync rise, zero if none
  task automatic run_comp(input int w);
    t = 0;
    fork
      src.green_pulse(w, 40);
      for (int i = 1; i <= 40; i++) begin
        @(posedge clk_i);
        if (fs === 1'b1 && t == 0) t = i;
        if (t != 0 && i == t + 2) c = coast;
        if (i == 10) g = gs;
      end
    join
  endtask
  // ==========
  // table rows, then the awkward cases by hand
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk("pslverr", {31'h0, e}, {31'h0, rows[i].e});
      if (!rows[i].wr) chk("prdata", q, rows[i].q);
    end
    chk("slicer level", {27'h0, slice}, 32'h15);
    chk("phase code", {27'h0, phase}, 32'h1f);
    chk("ext clock", {31'h0, ext}, 32'h1);
    run_comp(4);
    chk("short pulse", t, 32'h0);
    run_comp(30);
    chk("vsync lag", {31'h0, t inside {[11:22]}}, 32'h1);
    chk("coast vsync", {31'h0, c}, 32'h1);
    chk("green out", {31'h0, g}, 32'h1);
    apb(1'b1, 12'h0c0, 32'h7f);
    run_lines(1'b1);
    chk("line count", {31'h0, hs > 2}, 32'h1);
    chk("line phase", {31'h0, ((t - 1) % 40) inside {[2:7]}}, 32'h1);
    chk("pll moves", {31'h0, n > 2}, 32'h1);
    src.coast_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    run_lines(1'b1);
    chk("coast pin", {31'h0, coast}, 32'h1);
    chk("pll held", n, 32'h0);
    apb(1'b1, 12'h060, 32'h40);
    repeat (5) @(posedge clk_i);
    chk("coast low pol", {31'h0, coast}, 32'h0);
    apb(1'b1, 12'h048, 32'h0);
    run_lines(1'b0);
    chk("low phase", {31'h0, ((t - 1) % 40) inside {[2:7]}}, 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, 12'h048, 32'h0);
    chk("hpol reset", q, 32'h30);
    conclude();
  end
endmodule // vsp_sync_proc_test
`default_nettype wire

// ---- tb/vsp_video_src.sv ----
// Purpose: video source model driving line, green sync and coast pin
// Assumes: called from the bench, changes lines right after rising edges
// Notes: green sync is active low and idles high like a sliced sync line
`timescale 1ns/1ns
`default_nettype none
module vsp_video_src (
  input wire logic clk_i,
  output logic [1:0] line_o,
  output logic [1:0] green_o,
  output logic coast_o
);
  // ==========
  // idle levels, driven from time zero
  initial begin
    line_o = 2'h0;
    green_o = 2'h3;
    coast_o = 1'b0;
  end
  // composite pulse of w cycles, then gap idle cycles
  task automatic green_pulse(input int w, input int gap);
    @(posedge clk_i) green_o <= 2'h0;
    repeat (w) @(posedge clk_i);
    green_o <= 2'h3;
    repeat (gap) @(posedge clk_i);
  endtask
  // n lines of 40 cycles, 10 of them at active level a
  task automatic lines(input logic a, input int n);
    repeat (n) begin
      @(posedge clk_i) line_o <= {2{a}};
      repeat (10) @(posedge clk_i);
      line_o <= {2{~a}};
      repeat (29) @(posedge clk_i);
    end
  endtask
endmodule // vsp_video_src
`default_nettype wire
